/* File: bench/pbmc_basic_mode_control_checker.sv */
// port assertions for the basic mode control register
`timescale 1ns/1ns
`default_nettype none
// ********
// checker
// ********
module pbmc_basic_mode_control_checker (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // pin and straps
  input wire logic power_down_request_pin_b_i,
  input wire logic strap_an_enable_i,
  input wire logic strap_duplex_i,
  // data side
  input wire logic mac_tx_en_i,
  input wire logic mac_rx_dv_o,
  input wire logic mac_col_o,
  input wire logic line_tx_en_o,
  // negotiation handshake
  input wire logic an_started_i,
  input wire logic an_restart_o,
  // mode outputs
  input wire logic [1:0] speed_o,
  input wire logic duplex_o,
  input wire logic an_enable_o,
  input wire logic power_down_o,
  input wire logic isolate_o,
  input wire logic soft_reset_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_RST_VALUES: assert property (
    $rose(rst_b_i) |-> speed_o == 2'b10 && !an_enable_o && !isolate_o && !power_down_o)
    else $error("reset mode values wrong");
  AST_AN_MASK: assert property (
    an_enable_o |-> duplex_o && !speed_o[0]) else $error("forced fields not masked");
  AST_PIN_PDOWN: assert property (
    !power_down_request_pin_b_i [*4] |=> power_down_o) else $error("pin not in power down");
  AST_QUIET_MAC: assert property (
    (isolate_o || power_down_o) && $past(isolate_o || power_down_o)
    |-> !mac_rx_dv_o && !mac_col_o && !line_tx_en_o) else $error("data path not quiet");
  AST_COL_DROP: assert property (
    !mac_tx_en_i |=> !mac_col_o) else $error("collision held too long");
  AST_RESTART_HOLD: assert property (
    an_restart_o && !an_started_i && !$past(an_started_i) && !soft_reset_o |=> an_restart_o)
    else $error("restart dropped early");
  AST_SRST_HOLD: assert property (
    $rose(soft_reset_o) |-> soft_reset_o [*8]) else $error("soft reset too short");
  AST_STRAP_RELOAD: assert property (
    $fell(soft_reset_o) |-> ##[1:2] (an_enable_o == strap_an_enable_i
    && duplex_o == (strap_an_enable_i || strap_duplex_i))) else $error("straps not reloaded");

  // main scenarios reached
  cover property ($fell(soft_reset_o));
  cover property (mac_col_o);
  cover property ($fell(an_restart_o));
endmodule // pbmc_basic_mode_control_checker

bind pbmc_basic_mode_control pbmc_basic_mode_control_checker u_chk (
  .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
  .power_down_request_pin_b_i(power_down_request_pin_b_i),
  .strap_an_enable_i(strap_an_enable_i), .strap_duplex_i(strap_duplex_i),
  .mac_tx_en_i(mac_tx_en_i), .mac_rx_dv_o(mac_rx_dv_o), .mac_col_o(mac_col_o),
  .line_tx_en_o(line_tx_en_o), .an_started_i(an_started_i), .an_restart_o(an_restart_o),
  .speed_o(speed_o), .duplex_o(duplex_o), .an_enable_o(an_enable_o),
  .power_down_o(power_down_o), .isolate_o(isolate_o), .soft_reset_o(soft_reset_o)
);
`default_nettype wire

/* File: bench/pbmc_basic_mode_control_tb.sv */
// self-checking bench for the basic mode control register
`timescale 1ns/1ns
`default_nettype none
`include "pbmc_consts.vh"
// ********
// bench top
// ********
module pbmc_basic_mode_control_tb;
  localparam logic [4:0] PHY = 5'h03; // strapped address
  localparam logic [4:0] R0 = `PBMC_ADDR_BASIC_MODE_CONTROL;
  localparam logic [4:0] RF = `PBMC_ADDR_EVENT_FLAGS;
  // stimulus
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic pd_b = 1'b1;
  logic st_an = 1'b0;
  logic st_dup = 1'b0;
  logic [7:0] txd = 8'h5a;
  logic tx_en = 1'b1;
  logic an_go = 1'b0;
  // observed
  wire mdc, sd, soe, m_o, m_oe, rx_dv, col, ltx_en, an_rs, dup, an_en, pd, iso, srst;
  wire [7:0] rxd, ltxd;
  wire [1:0] spd;
  wire [5:0] mode = {spd, dup, an_en, pd, iso};
  // pulled-up line: released means high
  wire mdio_w = m_oe ? m_o : (soe ? sd : 1'b1);
  // bookkeeping
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  logic [15:0] q;
  logic [21:0] rows [0:7]; // written word, expected mode

  pbmc_basic_mode_control #(.DEAD_TIME_CYCLES(16'd20)) u_dut (
    .ref_clk_i(clk), .rst_b_i(rst_b), .mdc_i(mdc), .mdio_i(mdio_w),
    .mdio_o(m_o), .mdio_oe_o(m_oe), .strap_phy_addr_i(PHY),
    .strap_an_enable_i(st_an), .strap_duplex_i(st_dup), .power_down_request_pin_b_i(pd_b),
    .mac_txd_i(txd), .mac_tx_en_i(tx_en), .mac_rxd_o(rxd), .mac_rx_dv_o(rx_dv),
    .mac_col_o(col), .line_rxd_i(8'ha5), .line_rx_dv_i(1'b1), .line_txd_o(ltxd),
    .line_tx_en_o(ltx_en), .an_started_i(an_go), .an_restart_o(an_rs), .speed_o(spd),
    .duplex_o(dup), .an_enable_o(an_en), .power_down_o(pd), .isolate_o(iso),
    .soft_reset_o(srst));
  pbmc_mgmt_station u_sta (
    .ref_clk_i(clk), .mdio_line_i(mdio_w), .mdc_o(mdc), .mdio_d_o(sd), .mdio_oe_o(soe));

  initial forever #5 clk = ~clk;

  // hang guard, well above the ~10k cycles the run needs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_errors++;
      conclude();
    end
  end

  task automatic chk_reg(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic e, input logic g);
    chk_reg(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic chk_mode(input string nm, input logic [5:0] e, input logic [5:0] g);
    chk_reg(nm, {10'h000, e}, {10'h000, g});
  endtask
  task automatic wr(input logic [15:0] v);
    u_sta.xfer(1'b0, PHY, R0, v, q);
  endtask
  task automatic rd_chk(input string nm, input logic [4:0] a, input logic [15:0] e, m);
    u_sta.xfer(1'b1, PHY, a, 16'h0000, q);
    chk_reg(nm, e, q & m);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    rows = '{{16'h2000, 6'b01_0000}, {16'h0000, 6'b00_0000}, {16'h2040, 6'b11_0000},
             {16'h0100, 6'b00_1000}, {16'h313f, 6'b00_1100}, {16'h0800, 6'b00_0010},
             {16'h0400, 6'b00_0001}, {16'h0040, 6'b10_0000}};
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk_mode("mode_rst", 6'b10_0000, mode);
    rd_chk("bmc_rst", R0, 16'h0040, 16'hffff);
    rd_chk("unmapped", 5'h05, 16'h0000, 16'hffff);
    u_sta.xfer(1'b1, 5'h04, R0, 16'h0000, q);
    chk_reg("other_phy", 16'hffff, q);
    $display("reset and refusals done");
    foreach (rows[i])
    begin
      wr(rows[i][21:6]);
      chk_mode("mode", rows[i][5:0], mode);
      chk_pin("line_tx_en", ~|rows[i][1:0], ltx_en);
      chk_pin("mac_rx_dv", ~|rows[i][1:0], rx_dv);
      rd_chk("bmc", R0, rows[i][21:6] & 16'hffc0, 16'hffff);
      $display("row %0d done", i);
    end
    chk_reg("line_pass", 16'h5aa5, {ltxd, rxd});
    rd_chk("flags_ll", RF, 16'h0000, 16'h000f);
    rd_chk("flags_ll2", RF, 16'h0002, 16'h000f);
    pd_b <= 1'b0;
    repeat (5) @(posedge clk);
    chk_pin("pd_pin", 1'b1, pd);
    rd_chk("bmc_pd", R0, 16'h0840, 16'hffff);
    rd_chk("flags_pd", RF, 16'h000a, 16'h000f);
    pd_b <= 1'b1;
    repeat (5) @(posedge clk);
    rd_chk("flags_up", RF, 16'h0002, 16'h000f);
    $display("power down pin done");
    wr(16'h0080);
    chk_pin("col_on", 1'b1, col);
    tx_en <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk_pin("col_off", 1'b0, col);
    @(posedge clk);
    tx_en <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk_pin("col_again", 1'b1, col);
    wr(16'h0000);
    rd_chk("flags_cor", RF, 16'h0006, 16'h000f);
    rd_chk("flags_cor2", RF, 16'h0002, 16'h000f);
    $display("collision test done");
    wr(16'h4000);
    chk_pin("lb_dead", 1'b0, rx_dv);
    chk_pin("lb_line", 1'b0, ltx_en);
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk_pin("lb_dv", 1'b1, rx_dv);
    chk_reg("lb_data", {8'h00, txd}, {8'h00, rxd});
    $display("loopback done");
    wr(16'h0200);
    chk_pin("rs_ignored", 1'b0, an_rs);
    wr(16'h1200);
    chk_pin("rs_on", 1'b1, an_rs);
    wr(16'h1000);
    rd_chk("bmc_rs", R0, 16'h1200, 16'hffff);
    @(posedge clk);
    an_go <= 1'b1;
    @(posedge clk);
    an_go <= 1'b0;
    repeat (3) @(posedge clk);
    chk_pin("rs_clr", 1'b0, an_rs);
    rd_chk("bmc_an", R0, 16'h1000, 16'hffff);
    $display("restart done");
    st_an <= 1'b1;
    st_dup <= 1'b1;
    wr(16'h8000);
    chk_pin("srst_on", 1'b1, srst);
    n = 0;
    while (srst === 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    chk_pin("srst_ends", 1'b1, n > 10 && n < 60);
    repeat (4) @(posedge clk);
    chk_mode("mode_strap", 6'b10_1100, mode);
    rd_chk("bmc_strap", R0, 16'h1140, 16'hffff);
    rd_chk("flags_lh", RF, 16'h0001, 16'h0001);
    rd_chk("flags_lh2", RF, 16'h0000, 16'h0001);
    $display("soft reset done");
    conclude();
  end
endmodule // pbmc_basic_mode_control_tb
`default_nettype wire

/* File: bench/pbmc_mgmt_station.sv */
// management station model that clocks frames onto the management pins
`timescale 1ns/1ns
`default_nettype none
`include "pbmc_consts.vh"
// ********
// management station
// ********
module pbmc_mgmt_station (
  // clock
  input wire logic ref_clk_i,
  // resolved data line
  input wire logic mdio_line_i,
  // station drive
  output logic mdc_o,
  output logic mdio_d_o,
  output logic mdio_oe_o
);
  // clock stands low outside frames
  initial
  begin
    mdc_o = 1'b0;
    mdio_d_o = 1'b1;
    mdio_oe_o = 1'b0;
  end

  // one bit: mdc low, then high
  task automatic bit_io(input logic b, input logic drv, output logic s);
    @(posedge ref_clk_i);
    mdc_o <= 1'b0;
    mdio_d_o <= b;
    mdio_oe_o <= drv;
    repeat (3) @(posedge ref_clk_i);
    // slave output settled here
    s = mdio_line_i;
    mdc_o <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
  endtask

  // whole frame, no preamble, msb first
  task automatic xfer(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] q);
    logic [13:0] hdr;
    logic s;
    hdr = {2'b01, rd ? `PBMC_OP_READ : `PBMC_OP_WRITE, phy, ra};
    for (int i = 13; i >= 0; i--)
      bit_io(hdr[i], 1'b1, s);
    // turnaround released on reads
    bit_io(1'b1, !rd, s);
    bit_io(1'b0, !rd, s);
    for (int i = 15; i >= 0; i--)
    begin
      bit_io(wd[i], !rd, s);
      q[i] = s;
    end
    @(posedge ref_clk_i);
    mdc_o <= 1'b0;
    mdio_oe_o <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
  endtask
endmodule // pbmc_mgmt_station
`default_nettype wire

/* File: rtl/pbmc_access_bit.v */
// one event field with a selectable management access type
`timescale 1ns/1ns
`default_nettype none
`include "pbmc_consts.vh"
module pbmc_access_bit #(
  parameter [1:0] KIND = 2'd0
) (
  // clock and reset
  input wire ref_clk_i,
  input wire rst_b_i,
  // event and management read pulse
  input wire event_i,
  input wire read_i,
  // field value
  output reg value_o
);
  // latched-low idles at one, the others at zero
  localparam IDLE = (KIND == `PBMC_ACC_LATCH_LOW) ? 1'b1 : 1'b0;

  // field update; the event wins over a read in the same cycle
  always @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
      value_o <= IDLE;
    else
    begin
      case (KIND)
        // RULE16 - latch high, hold
        `PBMC_ACC_LATCH_HIGH: value_o <= event_i | (value_o & ~read_i);
        // RULE17 - latch low, hold
        `PBMC_ACC_LATCH_LOW: value_o <= ~event_i & (value_o | read_i);
        // RULE18 - clear after read
        `PBMC_ACC_CLEAR_ON_READ: value_o <= event_i | (value_o & ~read_i);
        // RULE19 - follows the event
        default: value_o <= event_i;
      endcase
    end
  end
endmodule // pbmc_access_bit
`default_nettype wire

/* File: rtl/pbmc_basic_mode_control.v */
// basic mode control register with management slave and data steering
`timescale 1ns/1ns
`default_nettype none
`include "pbmc_consts.vh"
module pbmc_basic_mode_control #(
  parameter [15:0] DEAD_TIME_CYCLES = `PBMC_DEAD_TIME_US * `PBMC_CLK_MHZ
) (
  // clock and reset
  input wire ref_clk_i,
  input wire rst_b_i,
  // serial management pins
  input wire mdc_i,
  input wire mdio_i,
  output reg mdio_o,
  output reg mdio_oe_o,
  // bootstrap pins
  input wire [4:0] strap_phy_addr_i,
  input wire strap_an_enable_i,
  input wire strap_duplex_i,
  // active-low power down pin
  input wire power_down_request_pin_b_i,
  // MAC side data
  input wire [7:0] mac_txd_i,
  input wire mac_tx_en_i,
  output reg [7:0] mac_rxd_o,
  output reg mac_rx_dv_o,
  output reg mac_col_o,
  // line side data
  input wire [7:0] line_rxd_i,
  input wire line_rx_dv_i,
  output reg [7:0] line_txd_o,
  output reg line_tx_en_o,
  // negotiation engine handshake
  input wire an_started_i,
  output reg an_restart_o,
  // operating mode
  output reg [1:0] speed_o,
  output reg duplex_o,
  output reg an_enable_o,
  output reg power_down_o,
  output reg isolate_o,
  output reg soft_reset_o
);

  // ********
  // management frame states
  // ********
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_START = 3'd1;
  localparam [2:0] S_HDR = 3'd2;
  localparam [2:0] S_TA = 3'd3;
  localparam [2:0] S_DATA = 3'd4;

  // ********
  // pin synchronisers
  // ********
  wire [3:0] pins_s; // mdc, mdio, power pin, negotiation strap
  wire dup_s; // duplex strap
  wire mdc_s;
  wire mdio_s;
  wire pdn_pin_b_s;
  wire [4:0] phy_addr_s;

  pbmc_sync #(
    .W(4)
  ) u_sync_mgmt (
    .ref_clk_i(ref_clk_i),
    .async_i({mdc_i, mdio_i, power_down_request_pin_b_i, strap_an_enable_i}),
    .sync_o(pins_s)
  );

  pbmc_sync #(
    .W(5)
  ) u_sync_addr (
    .ref_clk_i(ref_clk_i),
    .async_i(strap_phy_addr_i),
    .sync_o(phy_addr_s)
  );

  pbmc_sync #(
    .W(1)
  ) u_sync_dup (
    .ref_clk_i(ref_clk_i),
    .async_i(strap_duplex_i),
    .sync_o(dup_s)
  );

  assign mdc_s = pins_s[3];
  assign mdio_s = pins_s[2];
  assign pdn_pin_b_s = pins_s[1];

  // ********
  // register fields
  // ********
  reg f_reset; // software reset in progress
  reg f_loop; // loopback
  reg f_speed_lsb; // forced speed low bit
  reg f_an_en; // negotiation enable
  reg f_pdn; // power down field
  reg f_iso; // isolate
  reg f_restart; // negotiation restart pending
  reg f_duplex; // forced duplex
  reg f_coltest; // collision test
  reg f_speed_msb; // forced speed high bit
  reg strap_load; // straps still to be loaded
  reg [7:0] sw_cnt; // software reset hold counter
  reg [4:0] phy_addr; // latched management address

  // ********
  // management slave state
  // ********
  reg [2:0] state;
  reg mdc_q; // previous synchronised mdc
  reg [3:0] bit_cnt;
  reg [15:0] shreg;
  reg is_read; // frame reads and addresses us
  reg is_write; // frame writes and addresses us
  reg [4:0] reg_addr;
  reg wr_pulse; // one cycle write strobe
  reg [15:0] wr_data;
  reg [4:0] wr_addr;
  reg rd_pulse; // one cycle read strobe
  reg [4:0] rd_addr;
  wire flags_rd = rd_pulse && (rd_addr == `PBMC_ADDR_EVENT_FLAGS); // event flag read
  wire mdc_rise;
  wire pin_pdn;
  wire pdn_eff;

  // ********
  // event fields and data path state
  // ********
  wire ev_rst_seen;
  wire ev_iso_ok;
  wire ev_col_seen;
  wire ev_pdn_now;
  reg loop_q; // loopback one cycle ago
  reg [15:0] dead_cnt; // receive dead time left
  reg rst_done; // software reset finished this cycle

  assign mdc_rise = mdc_s & ~mdc_q;
  // RULE8 - field OR pin
  assign pin_pdn = ~pdn_pin_b_s;
  assign pdn_eff = f_pdn | pin_pdn;

  // ********
  // read value assembly
  // ********
  // shared by frame read-out for every address
  function [15:0] read_value;
    input [4:0] addr;
    begin
      read_value = 16'h0000;
      if (addr == `PBMC_ADDR_BASIC_MODE_CONTROL)
      begin
        read_value[`PBMC_BIT_RESET] = f_reset;
        read_value[`PBMC_BIT_LOOPBACK] = f_loop;
        read_value[`PBMC_BIT_SPEED_LSB] = f_speed_lsb;
        read_value[`PBMC_BIT_AN_ENABLE] = f_an_en;
        // RULE8 - pin reads as set
        read_value[`PBMC_BIT_POWER_DOWN] = pdn_eff;
        read_value[`PBMC_BIT_ISOLATE] = f_iso;
        read_value[`PBMC_BIT_AN_RESTART] = f_restart;
        read_value[`PBMC_BIT_DUPLEX] = f_duplex;
        read_value[`PBMC_BIT_COL_TEST] = f_coltest;
        read_value[`PBMC_BIT_SPEED_MSB] = f_speed_msb;
        // RULE15 - reserved read zero
        read_value[5:0] = 6'h00;
      end
      else if (addr == `PBMC_ADDR_EVENT_FLAGS)
        read_value[3:0] = {ev_pdn_now, ev_col_seen, ev_iso_ok, ev_rst_seen};
    end
  endfunction

  // ********
  // management frame receiver and driver
  // ********
  // RULE21 - runs whatever the power state
  // sampled on mdc rise; our output changes right after it
  always @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      state <= S_IDLE;
      mdc_q <= 1'b0;
      bit_cnt <= 4'h0;
      shreg <= 16'h0000;
      is_read <= 1'b0;
      is_write <= 1'b0;
      reg_addr <= 5'h00;
      wr_pulse <= 1'b0;
      wr_data <= 16'h0000;
      wr_addr <= 5'h00;
      rd_pulse <= 1'b0;
      rd_addr <= 5'h00;
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
    end
    else
    begin
      mdc_q <= mdc_s;
      wr_pulse <= 1'b0;
      rd_pulse <= 1'b0;
      if (mdc_rise)
      begin
        case (state)
          // preamble ones, frame begins with a zero
          S_IDLE:
          begin
            if (!mdio_s)
              state <= S_START;
          end
          // second start bit must be one
          S_START:
          begin
            bit_cnt <= 4'h0;
            state <= mdio_s ? S_HDR : S_IDLE;
          end
          // opcode, phy address, register address
          S_HDR:
          begin
            shreg <= {shreg[14:0], mdio_s};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == 4'hb)
            begin
              is_read <= (shreg[10:9] == `PBMC_OP_READ) &&
                (shreg[8:4] == phy_addr);
              is_write <= (shreg[10:9] == `PBMC_OP_WRITE) &&
                (shreg[8:4] == phy_addr);
              reg_addr <= {shreg[3:0], mdio_s};
              bit_cnt <= 4'h0;
              state <= S_TA;
            end
          end
          // turnaround: drive zero in its second half for reads
          S_TA:
          begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == 4'h0)
            begin
              mdio_oe_o <= is_read;
              mdio_o <= 1'b0;
            end
            else
            begin
              bit_cnt <= 4'h0;
              state <= S_DATA;
              if (is_read)
              begin
                shreg <= read_value(reg_addr);
                mdio_o <= |(read_value(reg_addr) & 16'h8000);
                rd_pulse <= 1'b1;
                rd_addr <= reg_addr;
              end
            end
          end
          // sixteen data bits, most significant first
          S_DATA:
          begin
            bit_cnt <= bit_cnt + 4'h1;
            if (is_read)
            begin
              shreg <= {shreg[14:0], 1'b0};
              mdio_o <= shreg[14];
            end
            else
              shreg <= {shreg[14:0], mdio_s};
            if (bit_cnt == 4'hf)
            begin
              mdio_oe_o <= 1'b0;
              wr_pulse <= is_write;
              wr_data <= {shreg[14:0], mdio_s};
              wr_addr <= reg_addr;
              state <= S_IDLE;
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // ********
  // control register fields
  // ********
  always @(posedge ref_clk_i)
  begin
    rst_done <= 1'b0;
    if (!rst_b_i)
    begin
      // RULE22 - reset values
      f_reset <= `PBMC_RST_OTHER;
      f_loop <= `PBMC_RST_OTHER;
      f_speed_lsb <= `PBMC_RST_OTHER;
      f_an_en <= `PBMC_RST_OTHER;
      f_pdn <= `PBMC_RST_OTHER;
      f_iso <= `PBMC_RST_OTHER;
      f_restart <= `PBMC_RST_OTHER;
      f_duplex <= `PBMC_RST_OTHER;
      f_coltest <= `PBMC_RST_OTHER;
      f_speed_msb <= `PBMC_RST_SPEED_MSB;
      strap_load <= 1'b1;
      sw_cnt <= 8'h00;
      phy_addr <= 5'h00;
    end
    else if (strap_load)
    begin
      // RULE20 - straps sampled after release
      f_an_en <= pins_s[0];
      f_duplex <= dup_s;
      phy_addr <= phy_addr_s;
      strap_load <= 1'b0;
    end
    else if (f_reset)
    begin
      // RULE1 - hold, then self-clear
      sw_cnt <= sw_cnt + 8'h01;
      if (sw_cnt == `PBMC_SW_RESET_CYCLES)
      begin
        f_reset <= 1'b0;
        f_loop <= `PBMC_RST_OTHER;
        f_speed_lsb <= `PBMC_RST_OTHER;
        f_pdn <= `PBMC_RST_OTHER;
        f_iso <= `PBMC_RST_OTHER;
        f_restart <= `PBMC_RST_OTHER;
        f_coltest <= `PBMC_RST_OTHER;
        f_speed_msb <= `PBMC_RST_SPEED_MSB;
        // RULE2 - restrap on software reset
        strap_load <= 1'b1;
        rst_done <= 1'b1;
      end
    end
    else
    begin
      // negotiation has begun: pending restart drops
      if (an_started_i)
        f_restart <= 1'b0;
      if (wr_pulse && (wr_addr == `PBMC_ADDR_BASIC_MODE_CONTROL))
      begin
        // RULE1 - write one starts reset
        f_reset <= wr_data[`PBMC_BIT_RESET];
        sw_cnt <= 8'h00;
        f_loop <= wr_data[`PBMC_BIT_LOOPBACK];
        f_speed_lsb <= wr_data[`PBMC_BIT_SPEED_LSB];
        f_an_en <= wr_data[`PBMC_BIT_AN_ENABLE];
        f_pdn <= wr_data[`PBMC_BIT_POWER_DOWN];
        f_iso <= wr_data[`PBMC_BIT_ISOLATE];
        f_duplex <= wr_data[`PBMC_BIT_DUPLEX];
        f_coltest <= wr_data[`PBMC_BIT_COL_TEST];
        f_speed_msb <= wr_data[`PBMC_BIT_SPEED_MSB];
        // RULE10 - ignored unless enabled
        // RULE11 - zero leaves restart alone
        if (wr_data[`PBMC_BIT_AN_RESTART] && wr_data[`PBMC_BIT_AN_ENABLE])
          f_restart <= 1'b1;
      end
    end
  end

  // ********
  // event fields, one of each access type
  // ********
  // latched high: a software reset has completed
  pbmc_access_bit #(
    .KIND(`PBMC_ACC_LATCH_HIGH)
  ) u_ev_rst (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .event_i(rst_done),
    .read_i(flags_rd),
    .value_o(ev_rst_seen)
  );

  // latched low: port has been isolated
  pbmc_access_bit #(
    .KIND(`PBMC_ACC_LATCH_LOW)
  ) u_ev_iso (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .event_i(f_iso),
    .read_i(flags_rd),
    .value_o(ev_iso_ok)
  );

  // clear on read: a test collision was signalled
  pbmc_access_bit #(
    .KIND(`PBMC_ACC_CLEAR_ON_READ)
  ) u_ev_col (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .event_i(mac_col_o),
    .read_i(flags_rd),
    .value_o(ev_col_seen)
  );

  // self clearing: power down is in force
  pbmc_access_bit #(
    .KIND(`PBMC_ACC_SELF_CLEAR)
  ) u_ev_pdn (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .event_i(pdn_eff),
    .read_i(1'b0),
    .value_o(ev_pdn_now)
  );

  // ********
  // data steering and mode outputs
  // ********
  // one register stage everywhere, so loopback adds one cycle
  always @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      loop_q <= 1'b0;
      dead_cnt <= 16'h0000;
      mac_rxd_o <= 8'h00;
      mac_rx_dv_o <= 1'b0;
      mac_col_o <= 1'b0;
      line_txd_o <= 8'h00;
      line_tx_en_o <= 1'b0;
      an_restart_o <= 1'b0;
      speed_o <= 2'b10;
      duplex_o <= 1'b0;
      an_enable_o <= 1'b0;
      power_down_o <= 1'b0;
      isolate_o <= 1'b0;
      soft_reset_o <= 1'b0;
    end
    else
    begin
      loop_q <= f_loop;
      // RULE4 - receive dead time on loopback entry
      if (f_loop && !loop_q)
        dead_cnt <= DEAD_TIME_CYCLES;
      else if (dead_cnt != 16'h0000)
        dead_cnt <= dead_cnt - 16'h0001;
      // RULE7 - powered down: data idle
      // RULE9 - isolated: MAC side idle
      if (pdn_eff || f_iso || f_reset)
      begin
        mac_rxd_o <= 8'h00;
        mac_rx_dv_o <= 1'b0;
        line_txd_o <= 8'h00;
        line_tx_en_o <= 1'b0;
      end
      else if (f_loop)
      begin
        // RULE3 - transmit back to receive
        mac_rxd_o <= mac_txd_i;
        // entry cycle held off too, before the counter loads
        mac_rx_dv_o <= mac_tx_en_i && loop_q && (dead_cnt == 16'h0000);
        line_txd_o <= 8'h00;
        line_tx_en_o <= 1'b0;
      end
      else
      begin
        mac_rxd_o <= line_rxd_i;
        mac_rx_dv_o <= line_rx_dv_i;
        line_txd_o <= mac_txd_i;
        line_tx_en_o <= mac_tx_en_i;
      end
      // RULE13 - collision follows transmit enable
      // RULE14 - drops one cycle after it
      mac_col_o <= f_coltest && mac_tx_en_i && !pdn_eff && !f_iso;
      // RULE5 - speed code {bit 6, bit 13}
      // RULE6 - low bit ignored when negotiating
      speed_o <= {f_speed_msb, f_speed_lsb & ~f_an_en};
      // RULE12 - forced duplex when not negotiating
      duplex_o <= f_an_en | f_duplex;
      an_enable_o <= f_an_en;
      an_restart_o <= f_restart;
      power_down_o <= pdn_eff;
      isolate_o <= f_iso;
      soft_reset_o <= f_reset;
    end
  end

endmodule // pbmc_basic_mode_control
`default_nettype wire

/* File: rtl/pbmc_consts.vh */
// constants for the basic mode control register block
`ifndef PBMC_CONSTS_VH
`define PBMC_CONSTS_VH
// Notes on behaviour
// RULE1 - bit 15 starts reset, reads one, self-clears
// RULE2 - software reset reloads straps like power-up
// RULE3 - bit 14 loops MAC transmit to receive
// RULE4 - receive data absent up to 500 us
// RULE5 - forced speed code from bits 6 and 13
// RULE6 - bit 12 strap default, masks bits 13, 8
// RULE7 - bit 11 powers down all but registers
// RULE8 - power down is field OR low pin
// RULE9 - bit 10 isolates MAC data, management stays
// RULE10 - bit 9 restarts negotiation, self-clears, needs enable
// RULE11 - writing zero to bit 9 changes nothing
// RULE12 - bit 8 forces duplex, strap default
// RULE13 - collision test raises collision on transmit enable
// RULE14 - collision drops within 4 bit times
// RULE15 - bits 5:0 ignore writes, read zero
// RULE16 - latched-high holds one until read
// RULE17 - latched-low holds zero until read
// RULE18 - clear-on-read returns value then clears
// RULE19 - self-clearing follows its event
// RULE20 - strap fields load pin level at reset
// RULE21 - management works while powered down
// RULE22 - reset value: speed high bit one only

// ********
// register addresses on the management bus
// ********
`define PBMC_ADDR_BASIC_MODE_CONTROL 5'h00
`define PBMC_ADDR_EVENT_FLAGS 5'h1e

// ********
// field positions of basic_mode_control
// ********
`define PBMC_BIT_RESET 15
`define PBMC_BIT_LOOPBACK 14
`define PBMC_BIT_SPEED_LSB 13
`define PBMC_BIT_AN_ENABLE 12
`define PBMC_BIT_POWER_DOWN 11
`define PBMC_BIT_ISOLATE 10
`define PBMC_BIT_AN_RESTART 9
`define PBMC_BIT_DUPLEX 8
`define PBMC_BIT_COL_TEST 7
`define PBMC_BIT_SPEED_MSB 6

// ********
// reset values of the non-strap fields
// ********
`define PBMC_RST_SPEED_MSB 1'b1
`define PBMC_RST_OTHER 1'b0

// ********
// management frame opcodes
// ********
`define PBMC_OP_WRITE 2'b01
`define PBMC_OP_READ 2'b10

// ********
// access types of event fields
// ********
`define PBMC_ACC_LATCH_HIGH 2'd0
`define PBMC_ACC_LATCH_LOW 2'd1
`define PBMC_ACC_CLEAR_ON_READ 2'd2
`define PBMC_ACC_SELF_CLEAR 2'd3

// ********
// timing
// ********
`define PBMC_CLK_MHZ 100
`define PBMC_DEAD_TIME_US 500
`define PBMC_SW_RESET_CYCLES 8'd32

`endif

/* File: rtl/pbmc_sync.v */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module pbmc_sync #(
  parameter W = 1
) (
  // clock
  input wire ref_clk_i,
  // asynchronous level in
  input wire [W-1:0] async_i,
  // synchronised level out
  output wire [W-1:0] sync_o
);
  // no reset: straps must be valid while the core reset is still held
  reg [W-1:0] meta;
  reg [W-1:0] stable;

  // first stage feeds only the second stage
  always @(posedge ref_clk_i)
  begin
    meta <= async_i;
    stable <= meta;
  end

  assign sync_o = stable;
endmodule // pbmc_sync
`default_nettype wire
